/* File: src/pas_pkg.sv */
// Constants shared by the strap-capture and PCI window block
package pas_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets on the APB
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CHIP_PIN_CONFIG  = 8'h00;
  localparam logic [7:0] OFF_WIN_SIZE_PCI32   = 8'h04;
  localparam logic [7:0] OFF_WIN_SIZE_PCI64   = 8'h08;
  localparam logic [7:0] OFF_MEM_WRITE_PROT   = 8'h0c;
  localparam logic [7:0] OFF_TIMER            = 8'h10;
  localparam logic [7:0] OFF_WIN_BASE_PCI32   = 8'h14;
  localparam logic [7:0] OFF_WIN_BASE_PCI64   = 8'h18;
  localparam logic [7:0] OFF_CFG_IDSEL_ADDR   = 8'h1c;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CPC_EXT4G_BIT     = 27;  // Extended 4GB addressing
  localparam int CPC_ARB32_BIT     = 16;  // 32-bit arbitration mode
  localparam int CPC_ARB64_BIT     = 9;   // 64-bit arbitration mode
  localparam int WIN_SIZE_LSB      = 24;  // Window size field 31:24
  localparam int WIN_SIZE_W        = 8;
  localparam int MWP_FINE_BIT      = 0;   // Fine granularity request
  localparam int MWP_FINE_EFF_BIT  = 1;   // Fine granularity in effect
  localparam int CFG_HIDE_MSB      = 13;  // Config address bits kept
  localparam int CFG_HIDE_LSB      = 11;  // inside the chip

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] RST_CHIP_PIN_CONFIG = 32'h0000_0000;
  localparam logic [31:0] RST_WIN_SIZE        = 32'h0000_0000;
  localparam logic [31:0] RST_WIN_BASE        = 32'h0000_0000;
  localparam logic [31:0] RST_MEM_WRITE_PROT  = 32'h0000_0000;
  localparam logic [31:0] RST_CFG_IDSEL_ADDR  = 32'h0000_0000;
  localparam logic [31:0] RST_TIMER           = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Synchroniser depth and mode encodings
  // ----------------------------------------------------------------------
  localparam int SYNC_STAGES   = 2;
  localparam logic ARB_INTERNAL = 1'b0;
  localparam logic ARB_EXTERNAL = 1'b1;

  // Capture sequencer states
  typedef enum logic [1:0] {
    CAP_WAIT_POWER = 2'b00,
    CAP_SAMPLE     = 2'b01,
    CAP_HOLD       = 2'b10
  } pas_cap_state_t;

endpackage

/* File: src/pas_sync.sv */
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module pas_sync
  import pas_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("pas_sync needs WIDTH of at least one");
  end

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage is read only by the second stage
  always_comb begin
    meta_d = asyncIn;
    sync_d = meta_q;
  end

  // Register both stages
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign syncOut = sync_q;

endmodule // pas_sync

`default_nettype wire

/* File: src/pas_strap_window.sv */
// Strap capture, PCI memory window decode and timer with APB registers
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// How it works
// (RULE1) Window size comes from bits 31:24
// (RULE2) Bit 27 extends PCI range to 4GB
// (RULE3) Extended range disables fine write-protect granularity
// (RULE4) Sample 32-bit strap during synth reset
// (RULE5) Strap low disables internal 32-bit arbiter
// (RULE6) Bit 16 reads 32-bit arbitration mode
// (RULE7) Sample 64-bit strap during synth reset
// (RULE8) Bit 9 reads 64-bit arbitration mode
// (RULE9) External arbiter must protect flash transactions
// (RULE10) Config address bits 13:11 stay internal
// (RULE11) Timers count only the PCI32 clock
// (RULE12) Captured straps hold until next power-on
module pas_strap_window
  import pas_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Power-on, strap and bus clock pins
  input  wire logic              power_valid_in,
  input  wire logic              clkSynthReset,
  input  wire logic              pci32_req2_strap,
  input  wire logic              pci64_req2_strap,
  input  wire logic              pci32ClkPin,
  // Inbound PCI addresses to decode
  input  wire logic [31:0]       pci32Addr,
  input  wire logic [31:0]       pci64Addr,
  // Results
  output logic                   pci32WinHit,
  output logic                   pci64WinHit,
  output logic                   pci32IntArbEn,
  output logic                   pci64IntArbEn,
  output logic                   fineGranEn,
  output logic      [31:0]       config_idsel_addr,
  output logic      [31:0]       timerCount
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (ADDR_W < 8) begin : g_bad_addr
    $error("pas_strap_window needs ADDR_W of at least eight");
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic powerValidS;
  logic synthResetS;
  logic strap32S;
  logic strap64S;
  logic pciClkS;

  // Straps and power pins are asynchronous to clk_sys
  pas_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .asyncIn ({pci32ClkPin, pci64_req2_strap, pci32_req2_strap,
               clkSynthReset, power_valid_in}),
    .syncOut ({pciClkS, strap64S, strap32S, synthResetS, powerValidS})
  );

  // ----------------------------------------------------------------------
  // Strap capture sequencer
  // ----------------------------------------------------------------------
  pas_cap_state_t capState_q;
  pas_cap_state_t capState_d;
  logic           arb32Mode_q;
  logic           arb32Mode_d;
  logic           arb64Mode_q;
  logic           arb64Mode_d;

  // Capture needs no PCI clock: it runs on clk_sys while synth reset
  // is still asserted, so a stopped PCI clock cannot miss the strap
  always_comb begin
    capState_d  = capState_q;
    arb32Mode_d = arb32Mode_q;
    arb64Mode_d = arb64Mode_q;
    unique case (capState_q)
      CAP_WAIT_POWER: begin
        if (powerValidS) begin
          capState_d = CAP_SAMPLE;
        end
      end
      CAP_SAMPLE: begin
        if (!powerValidS) begin
          capState_d = CAP_WAIT_POWER;
        end else if (synthResetS) begin
          // Strap low selects an external arbiter
          arb32Mode_d = strap32S ? ARB_INTERNAL : ARB_EXTERNAL; // [RULE4]
          arb64Mode_d = strap64S ? ARB_INTERNAL : ARB_EXTERNAL; // [RULE7]
          capState_d  = CAP_HOLD;
        end
      end
      CAP_HOLD: begin
        // Only a new power cycle rearms; request pin traffic is ignored
        if (!powerValidS) begin
          capState_d = CAP_WAIT_POWER; // [RULE12]
        end
      end
      default: capState_d = CAP_WAIT_POWER;
    endcase
  end

  // Register the capture state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      capState_q  <= CAP_WAIT_POWER;
      arb32Mode_q <= ARB_INTERNAL;
      arb64Mode_q <= ARB_INTERNAL;
    end else begin
      capState_q  <= capState_d;
      arb32Mode_q <= arb32Mode_d;
      arb64Mode_q <= arb64Mode_d;
    end
  end

  // ----------------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------------
  logic        apbWrite;
  logic        apbRead;
  logic [7:0]  regAddr;
  logic        addrOk;
  logic        ext4g_q;
  logic        ext4g_d;
  logic [WIN_SIZE_W-1:0] winSize_q [2];
  logic [WIN_SIZE_W-1:0] winSize_d [2];
  logic [WIN_SIZE_W-1:0] winBase_q [2];
  logic [WIN_SIZE_W-1:0] winBase_d [2];
  logic        fineReq_q;
  logic        fineReq_d;
  logic [31:0] cfgAddr_q;
  logic [31:0] cfgAddr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic [31:0] timer_q;
  logic [31:0] timer_d;

  // Zero-wait-state slave: access phase completes on its first cycle
  assign apbWrite = psel && penable && pwrite;
  assign apbRead  = psel && !penable && !pwrite;
  assign regAddr  = paddr[7:0];

  // Address decode; upper address bits must be zero
  always_comb begin
    addrOk = 1'b0;
    if (paddr[ADDR_W-1:2] == (ADDR_W-2)'(regAddr[7:2]) &&
        regAddr[1:0] == 2'h0) begin
      unique case (regAddr)
        OFF_CHIP_PIN_CONFIG, OFF_WIN_SIZE_PCI32, OFF_WIN_SIZE_PCI64,
        OFF_MEM_WRITE_PROT, OFF_TIMER, OFF_WIN_BASE_PCI32,
        OFF_WIN_BASE_PCI64, OFF_CFG_IDSEL_ADDR: addrOk = 1'b1;
        default: addrOk = 1'b0;
      endcase
    end
  end

  // Write side
  always_comb begin
    ext4g_d   = ext4g_q;
    winSize_d = winSize_q;
    winBase_d = winBase_q;
    fineReq_d = fineReq_q;
    cfgAddr_d = cfgAddr_q;
    if (apbWrite && addrOk) begin
      unique case (regAddr)
        OFF_CHIP_PIN_CONFIG: ext4g_d = pwdata[CPC_EXT4G_BIT]; // [RULE2]
        OFF_WIN_SIZE_PCI32:
          winSize_d[0] = pwdata[WIN_SIZE_LSB +: WIN_SIZE_W]; // [RULE1]
        OFF_WIN_SIZE_PCI64:
          winSize_d[1] = pwdata[WIN_SIZE_LSB +: WIN_SIZE_W]; // [RULE1]
        OFF_WIN_BASE_PCI32:
          winBase_d[0] = pwdata[WIN_SIZE_LSB +: WIN_SIZE_W];
        OFF_WIN_BASE_PCI64:
          winBase_d[1] = pwdata[WIN_SIZE_LSB +: WIN_SIZE_W];
        OFF_MEM_WRITE_PROT: fineReq_d = pwdata[MWP_FINE_BIT];
        OFF_CFG_IDSEL_ADDR: cfgAddr_d = pwdata;
        default: ext4g_d = ext4g_q; // Timer is read-only
      endcase
    end
  end

  // Read side: data is registered in the setup cycle
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (apbRead) begin
      prdata_d = 32'h0000_0000;
      unique case (regAddr)
        OFF_CHIP_PIN_CONFIG: begin
          prdata_d[CPC_EXT4G_BIT] = ext4g_q;
          prdata_d[CPC_ARB32_BIT] = arb32Mode_q; // [RULE6]
          prdata_d[CPC_ARB64_BIT] = arb64Mode_q; // [RULE8]
        end
        OFF_WIN_SIZE_PCI32:
          prdata_d[WIN_SIZE_LSB +: WIN_SIZE_W] = winSize_q[0];
        OFF_WIN_SIZE_PCI64:
          prdata_d[WIN_SIZE_LSB +: WIN_SIZE_W] = winSize_q[1];
        OFF_WIN_BASE_PCI32:
          prdata_d[WIN_SIZE_LSB +: WIN_SIZE_W] = winBase_q[0];
        OFF_WIN_BASE_PCI64:
          prdata_d[WIN_SIZE_LSB +: WIN_SIZE_W] = winBase_q[1];
        OFF_MEM_WRITE_PROT: begin
          prdata_d[MWP_FINE_BIT]     = fineReq_q;
          prdata_d[MWP_FINE_EFF_BIT] = fineGranEn;
        end
        OFF_TIMER:          prdata_d = timer_q;
        OFF_CFG_IDSEL_ADDR: prdata_d = cfgAddr_q;
        default:            prdata_d = 32'h0000_0000;
      endcase
      pslverr_d = !addrOk;
    end else if (psel && penable) begin
      pslverr_d = pslverr_q;
    end
  end

  // Register file and read data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext4g_q   <= RST_CHIP_PIN_CONFIG[CPC_EXT4G_BIT];
      winSize_q <= '{default: RST_WIN_SIZE[WIN_SIZE_LSB +: WIN_SIZE_W]};
      winBase_q <= '{default: RST_WIN_BASE[WIN_SIZE_LSB +: WIN_SIZE_W]};
      fineReq_q <= RST_MEM_WRITE_PROT[MWP_FINE_BIT];
      cfgAddr_q <= RST_CFG_IDSEL_ADDR;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      ext4g_q   <= ext4g_d;
      winSize_q <= winSize_d;
      winBase_q <= winBase_d;
      fineReq_q <= fineReq_d;
      cfgAddr_q <= cfgAddr_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  // Writes to unmapped addresses also flag an error in the access phase
  assign pslverr = psel && penable && (pwrite ? !addrOk : pslverr_q);

  // ----------------------------------------------------------------------
  // PCI32-clocked timer
  // ----------------------------------------------------------------------
  logic        pciClkDly_q;
  logic        pciClkDly_d;

  // Edge found from the synchronised copy; the PCI32 clock must be slower
  // than half of clk_sys or edges are lost
  always_comb begin
    pciClkDly_d = pciClkS;
    timer_d     = timer_q;
    if (pciClkS && !pciClkDly_q) begin
      timer_d = timer_q + 32'h0000_0001; // [RULE11]
    end
  end

  // Register the timer
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pciClkDly_q <= 1'b0;
      timer_q     <= RST_TIMER;
    end else begin
      pciClkDly_q <= pciClkDly_d;
      timer_q     <= timer_d;
    end
  end

  assign timerCount = timer_q;

  // ----------------------------------------------------------------------
  // Inbound window decode, one per PCI interface
  // ----------------------------------------------------------------------
  logic [31:0] pciAddr [2];
  logic [1:0]  winHit_q;
  logic [1:0]  winHit_d;

  assign pciAddr[0] = pci32Addr;
  assign pciAddr[1] = pci64Addr;

  // Size bits mask the compared top byte; without the extension the top
  // address bit must be clear, which caps the range at 2GB
  for (genvar i = 0; i < 2; i++) begin : g_win
    always_comb begin
      winHit_d[i] = (((pciAddr[i][31:24] ^ winBase_q[i]) & winSize_q[i])
                     == 8'h00) &&                            // [RULE1]
                    (ext4g_q || !pciAddr[i][31]);            // [RULE2]
    end
  end

  // Register the hits
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      winHit_q <= 2'b00;
    end else begin
      winHit_q <= winHit_d;
    end
  end

  assign pci32WinHit = winHit_q[0];
  assign pci64WinHit = winHit_q[1];

  // ----------------------------------------------------------------------
  // Outputs derived from captured and programmed state
  // ----------------------------------------------------------------------
  // An external 32-bit arbiter is trusted to keep flash cycles intact
  assign pci32IntArbEn = (arb32Mode_q == ARB_INTERNAL); // [RULE5] [RULE9]
  assign pci64IntArbEn = (arb64Mode_q == ARB_INTERNAL);
  assign fineGranEn    = fineReq_q && !ext4g_q;         // [RULE3]

  // Address bits 13:11 are forced low so they never leave the chip
  always_comb begin
    config_idsel_addr = cfgAddr_q;
    config_idsel_addr[CFG_HIDE_MSB:CFG_HIDE_LSB] = 3'h0; // [RULE10]
  end

endmodule // pas_strap_window

`default_nettype wire

/* File: tb/pas_strap_window_checker.sv */
// Concurrent checks on the strap capture and window block ports
`timescale 1ns/1ps
`default_nettype none

module pas_strap_window_checker
  import pas_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              clkSynthReset,
  input wire logic              pci32ClkPin,
  input wire logic              pci32WinHit,
  input wire logic              pci32IntArbEn,
  input wire logic              pci64IntArbEn,
  input wire logic              fineGranEn,
  input wire logic [31:0]       config_idsel_addr,
  input wire logic [31:0]       timerCount
);
  // --------------------------------------------------------------------
  // Bus phase decode
  // --------------------------------------------------------------------
  wire logic wrAcc = psel && penable && pwrite;
  wire logic rdSet = psel && !penable && !pwrite;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  property p_cfg_hide;
    wrAcc && paddr == OFF_CFG_IDSEL_ADDR |=>
      config_idsel_addr == ($past(pwdata) & 32'hffff_c7ff);
  endproperty
  a_cfg_hide: assert property (p_cfg_hide)
    else $error("config address bits 13:11 leak out");

  property p_fine_off;
    wrAcc && paddr == OFF_CHIP_PIN_CONFIG && pwdata[27] |=> !fineGranEn;
  endproperty
  a_fine_off: assert property (p_fine_off)
    else $error("fine granularity left on with 4GB range");

  // Six quiet cycles cover the synchroniser and capture latency
  property p_hold32;
    !clkSynthReset [*6] |=> $stable(pci32IntArbEn);
  endproperty
  a_hold32: assert property (p_hold32)
    else $error("32-bit arbiter mode moved outside capture");

  property p_hold64;
    !clkSynthReset [*6] |=> $stable(pci64IntArbEn);
  endproperty
  a_hold64: assert property (p_hold64)
    else $error("64-bit arbiter mode moved outside capture");

  property p_mode32;
    rdSet && paddr == OFF_CHIP_PIN_CONFIG |=>
      prdata[16] == !$past(pci32IntArbEn);
  endproperty
  a_mode32: assert property (p_mode32)
    else $error("32-bit mode bit disagrees with arbiter enable");

  property p_mode64;
    rdSet && paddr == OFF_CHIP_PIN_CONFIG |=>
      prdata[9] == !$past(pci64IntArbEn);
  endproperty
  a_mode64: assert property (p_mode64)
    else $error("64-bit mode bit disagrees with arbiter enable");

  property p_tmr_idle;
    !pci32ClkPin [*5] |=> $stable(timerCount);
  endproperty
  a_tmr_idle: assert property (p_tmr_idle)
    else $error("timer moved without a bus clock edge");

  property p_tmr_step;
    $changed(timerCount) |-> timerCount == $past(timerCount) + 32'h1;
  endproperty
  a_tmr_step: assert property (p_tmr_step)
    else $error("timer stepped by other than one");

  c_ext32: cover property ($fell(pci32IntArbEn));
  c_hit32: cover property (pci32WinHit);
  c_fine: cover property ($rose(fineGranEn));
endmodule // pas_strap_window_checker

bind pas_strap_window pas_strap_window_checker #(.ADDR_W(ADDR_W))
  i_pas_strap_window_checker (.clk_sys, .reset_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .clkSynthReset, .pci32ClkPin,
  .pci32WinHit, .pci32IntArbEn, .pci64IntArbEn, .fineGranEn,
  .config_idsel_addr, .timerCount);

`default_nettype wire

/* File: tb/pas_far_side.sv */
// Board-side model: power, clock-synth reset, strap pins, bus clock
`timescale 1ns/1ps
`default_nettype none

module pas_far_side (
  input  wire logic clk_sys,
  input  wire logic powerOn,
  input  wire logic strap32Level,
  input  wire logic strap64Level,
  input  wire logic clkRun,
  output var  logic power_valid_in,
  output logic      clkSynthReset,
  output logic      pci32_req2_strap,
  output logic      pci64_req2_strap,
  output var  logic pci32ClkPin
);
  logic [3:0] rstCnt = 4'h8;
  logic [1:0] div    = 2'h0;

  initial power_valid_in = 1'b0;
  initial pci32ClkPin    = 1'b0;

  // Synth reset stays high until eight cycles after power is valid
  always @(posedge clk_sys) begin
    power_valid_in <= powerOn;
    if (!power_valid_in) rstCnt <= 4'h8;
    else if (rstCnt != 4'h0) rstCnt <= rstCnt - 4'h1;
    // Bus clock halts only low, so no half edge is left pending
    if (clkRun || pci32ClkPin) begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      if (div == 2'h2) pci32ClkPin <= ~pci32ClkPin;
    end
  end

  assign clkSynthReset = (rstCnt != 4'h0);
  // A low strap announces an external arbiter that guards flash cycles
  assign pci32_req2_strap = strap32Level;
  assign pci64_req2_strap = strap64Level;
endmodule // pas_far_side

`default_nettype wire

/* File: tb/pas_strap_window_test.sv */
// Self-checking testbench for the strap capture and window block
`timescale 1ns/1ps
`default_nettype none

module pas_strap_window_test;
  import pas_pkg::*;
  logic        clk_sys, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, pci32Addr, pci64Addr, cfgOut, timerCount;
  logic        powerValid, synthRst, strap32, strap64, busClk;
  logic        hit32, hit64, arb32, arb64, fineGranEn;
  logic        powerOn, strap32Level, strap64Level, clkRun;
  int          errors, checked;

  pas_strap_window i_pas_strap_window (.clk_sys, .reset_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .power_valid_in(powerValid), .clkSynthReset(synthRst),
    .pci32_req2_strap(strap32), .pci64_req2_strap(strap64),
    .pci32ClkPin(busClk), .pci32Addr, .pci64Addr, .pci32WinHit(hit32),
    .pci64WinHit(hit64), .pci32IntArbEn(arb32), .pci64IntArbEn(arb64),
    .fineGranEn, .config_idsel_addr(cfgOut), .timerCount);

  pas_far_side i_pas_far_side (.clk_sys, .powerOn, .strap32Level,
    .strap64Level, .clkRun, .power_valid_in(powerValid),
    .clkSynthReset(synthRst), .pci32_req2_strap(strap32),
    .pci64_req2_strap(strap64), .pci32ClkPin(busClk));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic complete_run();
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; only the watchdog ends a wait on a dead slave
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-raises psel in this step
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset_regs();
    logic [31:0] r;
    logic        e;
    check(arb32, 1'b1);
    apb(1'b0, OFF_CHIP_PIN_CONFIG, 32'h0, r, e);
    check(r, RST_CHIP_PIN_CONFIG);
    wr(OFF_TIMER, 32'h0000_00ff);
    apb(1'b0, OFF_TIMER, 32'h0, r, e);
    check(r, RST_TIMER);
    apb(1'b0, 8'h20, 32'h0, r, e);
    check({r[31:1], e}, 32'h1);
  endtask

  // Power-on capture, then strap pins moved while the mode must hold
  task automatic t_strap(input logic s32, input logic s64);
    logic [31:0] r;
    logic        e;
    powerOn <= 1'b0;
    repeat (12) @(posedge clk_sys);
    strap32Level <= s32;
    strap64Level <= s64;
    powerOn      <= 1'b1;
    repeat (20) @(posedge clk_sys);
    check(arb32, s32);
    check(arb64, s64);
    apb(1'b0, OFF_CHIP_PIN_CONFIG, 32'h0, r, e);
    check(r & 32'h0001_0200, {15'h0, ~s32, 6'h0, ~s64, 9'h0});
    strap32Level <= ~s32;
    strap64Level <= ~s64;
    repeat (20) @(posedge clk_sys);
    check({arb32, arb64}, {s32, s64});
  endtask

  task automatic t_window();
    logic [31:0] r;
    logic        e;
    wr(OFF_WIN_SIZE_PCI32, 32'hc000_0000);
    wr(OFF_WIN_BASE_PCI32, 32'hc000_0000);
    wr(OFF_WIN_SIZE_PCI64, 32'hff00_0000);
    wr(OFF_WIN_BASE_PCI64, 32'h4100_0000);
    wr(OFF_CHIP_PIN_CONFIG, 32'h0);
    pci32Addr <= 32'hc123_4567;
    pci64Addr <= 32'h4100_0010;
    repeat (2) @(posedge clk_sys);
    check({hit32, hit64}, 2'b01);
    pci64Addr <= 32'h4200_0000;
    repeat (2) @(posedge clk_sys);
    check(hit64, 1'b0);
    wr(OFF_CHIP_PIN_CONFIG, 32'h0800_0000);
    repeat (2) @(posedge clk_sys);
    check(hit32, 1'b1);
    apb(1'b0, OFF_CHIP_PIN_CONFIG, 32'h0, r, e);
    check(r[27], 1'b1);
    pci32Addr <= 32'h4123_0000;
    repeat (2) @(posedge clk_sys);
    check(hit32, 1'b0);
  endtask

  task automatic t_fine();
    logic [31:0] r;
    logic        e;
    wr(OFF_CHIP_PIN_CONFIG, 32'h0);
    wr(OFF_MEM_WRITE_PROT, 32'h1);
    @(posedge clk_sys);
    check(fineGranEn, 1'b1);
    apb(1'b0, OFF_MEM_WRITE_PROT, 32'h0, r, e);
    check(r, 32'h3);
    wr(OFF_CHIP_PIN_CONFIG, 32'h0800_0000);
    @(posedge clk_sys);
    check(fineGranEn, 1'b0);
    apb(1'b0, OFF_MEM_WRITE_PROT, 32'h0, r, e);
    check(r, 32'h1);
  endtask

  task automatic t_cfg();
    logic [31:0] r;
    logic        e;
    wr(OFF_CFG_IDSEL_ADDR, 32'hffff_ffff);
    @(posedge clk_sys);
    check(cfgOut, 32'hffff_c7ff);
    apb(1'b0, OFF_CFG_IDSEL_ADDR, 32'h0, r, e);
    check(r, 32'hffff_ffff);
  endtask

  // Count bus clock rises here and compare with the timer afterwards
  task automatic t_timer();
    logic [31:0] r, t0;
    logic        e, prev;
    int          rises;
    t0 = timerCount;
    rises = 0;
    prev = busClk;
    clkRun <= 1'b1;
    repeat (70) begin
      @(posedge clk_sys);
      if (busClk && !prev) rises++;
      prev = busClk;
      if (rises == 9) clkRun <= 1'b0;
    end
    check(timerCount, t0 + 32'(rises));
    apb(1'b0, OFF_TIMER, 32'h0, r, e);
    check(r, t0 + 32'(rises));
  endtask

  // --------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #1_000_000;
    errors++;
    complete_run();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pci32Addr, pci64Addr, powerOn, clkRun} = '0;
    {strap32Level, strap64Level} = 2'b11;
    errors = 0;
    checked = 0;
    reset_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_reset_regs();
    t_strap(1'b0, 1'b1);
    t_strap(1'b1, 1'b0);
    t_window();
    t_fine();
    t_cfg();
    t_timer();
    complete_run();
  end
endmodule // pas_strap_window_test

`default_nettype wire
